// [core/tpsc_regs.sv]
module tpsc_regs (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_in,
	// configuration serial port, sampled on ref_clk_in
	input wire logic spi_sclk_in,
	input wire logic spi_cs_n_in,
	input wire logic spi_mosi_in,
	output logic spi_miso_out,
	// spacing fields held elsewhere
	input wire logic [7:0] slot_spacing_mant_in,
	input wire logic [1:0] slot_spacing_exp_in,
	// packet handler side
	input wire logic fifo_first_byte_valid_in,
	input wire logic [7:0] fifo_first_byte_in,
	input wire logic fifo_bit_in,
	input wire logic gp_pin_zero_in,
	input wire logic bit_adv_in,
	// packet configuration
	output logic [15:0] sync_pattern_out,
	output logic [7:0] payload_size_out,
	output logic payload_size_valid_out,
	output logic unbounded_packet_out,
	output logic check_append_out,
	output logic [1:0] data_source_format_out,
	output logic tx_bit_out,
	output logic packet_handling_out,
	// synthesizer and modem
	output logic [tpsc_pkg::SYNTH_WORD_W-1:0] synth_word_out,
	output logic [tpsc_pkg::RATE_WORD_W-1:0] symbol_rate_word_out
);

	////////////////////////////////////////////////////////////////////////
	// configuration registers
	logic [7:0] sync_pattern_high; // upper sync byte
	logic [7:0] sync_pattern_low; // lower sync byte
	logic [7:0] fixed_payload_size; // packet size, fixed policy
	logic pkt_tune; // tuning bit, stored only
	logic [1:0] data_source_format; // where transmit bits come from
	logic check_enable; // append check value
	logic [1:0] size_policy; // how payload size is found
	logic [7:0] rf_slot_index; // channel number
	logic [7:0] carrier_trim; // signed synth offset
	logic [5:0] carrier_word_high; // writable part of top byte
	logic [7:0] carrier_word_mid;
	logic [7:0] carrier_word_low;
	logic [3:0] rate_upper; // upper nibble, stored only
	logic [3:0] symbol_rate_exp;
	logic [7:0] symbol_rate_mant;

	// serial port state
	logic sclk_prev; // last sampled serial clock
	logic [2:0] bit_cnt; // bit within current byte
	logic [7:0] shift_in; // incoming byte
	logic [7:0] shift_out; // outgoing byte
	logic header_done; // header byte seen in this frame
	logic read_mode; // frame is a read
	logic burst_mode; // frame auto increments
	logic [5:0] addr; // current register address
	logic [7:0] next_shift_in;
	logic byte_done; // last bit of a byte sampled this cycle
	logic wr_strobe; // data byte complete in write frame
	logic sclk_rise, sclk_fall; // serial clock edges, frame selected

	// derived words
	logic [23:0] base_carrier_word;
	logic [tpsc_pkg::SYNTH_WORD_W-1:0] next_synth_word;
	logic [tpsc_pkg::RATE_WORD_W-1:0] next_rate_word;

	// register read mux, shared by header and burst advance
	function automatic logic [7:0] read_reg(input logic [5:0] a);
		logic [7:0] d;
		d = 8'h00;
		unique case (a)
			tpsc_pkg::ADDR_SYNC_HIGH: d = sync_pattern_high;
			tpsc_pkg::ADDR_SYNC_LOW: d = sync_pattern_low;
			tpsc_pkg::ADDR_PAYLOAD_SIZE: d = fixed_payload_size;
			// bits 7 and 3 read zero
			tpsc_pkg::ADDR_PKT_CTRL: d = {1'b0, pkt_tune,
				data_source_format, 1'b0, check_enable, size_policy};
			tpsc_pkg::ADDR_SLOT_INDEX: d = rf_slot_index;
			tpsc_pkg::ADDR_OFFSET_TRIM: d = carrier_trim;
			tpsc_pkg::ADDR_CARRIER_HIGH: d = {2'b00, carrier_word_high};
			tpsc_pkg::ADDR_CARRIER_MID: d = carrier_word_mid;
			tpsc_pkg::ADDR_CARRIER_LOW: d = carrier_word_low;
			tpsc_pkg::ADDR_RATE_EXP: d = {rate_upper, symbol_rate_exp};
			tpsc_pkg::ADDR_RATE_MANT: d = symbol_rate_mant;
			// unmapped addresses read zero
			default: d = 8'h00;
		endcase
		return d;
	endfunction

	// mantissa with hidden one, shifted by exponent
	function automatic logic [23:0] scale(input logic [7:0] mant,
		input logic [3:0] expo);
		logic [23:0] m;
		m = {15'h0000, tpsc_pkg::HIDDEN_ONE | {1'b0, mant}};
		return m << expo;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// serial port edge detect; inputs already in this clock domain
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			sclk_prev <= 1'b0;
		end else begin
			sclk_prev <= spi_sclk_in;
		end
	end

	assign sclk_rise = spi_sclk_in && !sclk_prev && !spi_cs_n_in;
	assign sclk_fall = !spi_sclk_in && sclk_prev && !spi_cs_n_in;
	assign next_shift_in = {shift_in[6:0], spi_mosi_in};
	assign byte_done = sclk_rise && (bit_cnt == 3'h7);
	assign wr_strobe = byte_done && header_done && !read_mode;

	// input shift and bit count; cs high restarts the frame
	always_ff @(posedge ref_clk_in) begin
		if (rst_in || spi_cs_n_in) begin
			bit_cnt <= 3'h0;
			shift_in <= 8'h00;
		end else if (sclk_rise) begin
			bit_cnt <= bit_cnt + 3'h1;
			shift_in <= next_shift_in;
		end
	end

	// header decode and address advance
	always_ff @(posedge ref_clk_in) begin
		if (rst_in || spi_cs_n_in) begin
			header_done <= 1'b0;
			read_mode <= 1'b0;
			burst_mode <= 1'b0;
			addr <= 6'h00;
		end else if (byte_done) begin
			if (!header_done) begin
				// first byte: direction, burst, address
				header_done <= 1'b1;
				read_mode <= next_shift_in[tpsc_pkg::HDR_READ_BIT];
				burst_mode <= next_shift_in[tpsc_pkg::HDR_BURST_BIT];
				addr <= next_shift_in[5:0];
			end else if (burst_mode) begin
				// burst walks to the next register
				addr <= addr + 6'h01;
			end
		end
	end

	// load at byte end; the fall right after a load keeps the msb standing
	always_ff @(posedge ref_clk_in) begin
		if (rst_in || spi_cs_n_in) begin
			shift_out <= 8'h00;
		end else if (byte_done) begin
			if (!header_done) begin
				shift_out <= read_reg(next_shift_in[5:0]);
			end else if (burst_mode) begin
				shift_out <= read_reg(addr + 6'h01);
			end else begin
				// single access repeats the same register
				shift_out <= read_reg(addr);
			end
		end else if (sclk_fall && bit_cnt != 3'h0) begin
			shift_out <= {shift_out[6:0], 1'b0};
		end
	end

	// serial output: msb of the shifter, low when idle
	assign spi_miso_out = shift_out[7] && read_mode && !spi_cs_n_in;

	////////////////////////////////////////////////////////////////////////
	// packet registers
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			sync_pattern_high <= tpsc_pkg::RST_SYNC_HIGH;
			sync_pattern_low <= tpsc_pkg::RST_SYNC_LOW;
			fixed_payload_size <= tpsc_pkg::RST_PAYLOAD_SIZE;
			pkt_tune <= tpsc_pkg::RST_PKT_TUNE;
			data_source_format <= tpsc_pkg::RST_SOURCE_FMT;
			check_enable <= tpsc_pkg::RST_CHECK_EN;
			size_policy <= tpsc_pkg::RST_SIZE_POLICY;
		end else if (wr_strobe) begin
			unique case (addr)
				tpsc_pkg::ADDR_SYNC_HIGH: sync_pattern_high <= next_shift_in;
				tpsc_pkg::ADDR_SYNC_LOW: sync_pattern_low <= next_shift_in;
				// zero is the host's fault; stored as given
				tpsc_pkg::ADDR_PAYLOAD_SIZE: fixed_payload_size <= next_shift_in;
				tpsc_pkg::ADDR_PKT_CTRL: begin
					// bits 7 and 3 not stored
					pkt_tune <= next_shift_in[tpsc_pkg::PKT_TUNE_BIT];
					data_source_format <=
						next_shift_in[tpsc_pkg::SOURCE_FMT_LSB +: 2];
					check_enable <= next_shift_in[tpsc_pkg::CHECK_EN_BIT];
					size_policy <= next_shift_in[tpsc_pkg::SIZE_POLICY_LSB +: 2];
				end
				default: ; // other offsets hold their value
			endcase
		end
	end

	// synthesizer and modem registers
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			rf_slot_index <= tpsc_pkg::RST_SLOT_INDEX;
			carrier_trim <= tpsc_pkg::RST_OFFSET_TRIM;
			carrier_word_high <= tpsc_pkg::RST_CARRIER_HIGH;
			carrier_word_mid <= tpsc_pkg::RST_CARRIER_MID;
			carrier_word_low <= tpsc_pkg::RST_CARRIER_LOW;
			rate_upper <= tpsc_pkg::RST_RATE_UPPER;
			symbol_rate_exp <= tpsc_pkg::RST_RATE_EXP;
			symbol_rate_mant <= tpsc_pkg::RST_RATE_MANT;
		end else if (wr_strobe) begin
			unique case (addr)
				tpsc_pkg::ADDR_SLOT_INDEX: rf_slot_index <= next_shift_in;
				tpsc_pkg::ADDR_OFFSET_TRIM: carrier_trim <= next_shift_in;
				tpsc_pkg::ADDR_CARRIER_HIGH:
					carrier_word_high <= next_shift_in[5:0];
				tpsc_pkg::ADDR_CARRIER_MID: carrier_word_mid <= next_shift_in;
				tpsc_pkg::ADDR_CARRIER_LOW: carrier_word_low <= next_shift_in;
				tpsc_pkg::ADDR_RATE_EXP: begin
					rate_upper <= next_shift_in[7:4];
					symbol_rate_exp <= next_shift_in[3:0];
				end
				tpsc_pkg::ADDR_RATE_MANT: symbol_rate_mant <= next_shift_in;
				default: ; // other offsets hold their value
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// frequency word in f_xtal/2^18 units, so all terms stay integer
	// carrier word from three bytes
	assign base_carrier_word = {2'b00, carrier_word_high,
		carrier_word_mid, carrier_word_low};

	always_comb begin
		logic [23:0] spacing;
		logic [tpsc_pkg::SYNTH_WORD_W-1:0] slot_term;
		logic [tpsc_pkg::SYNTH_WORD_W-1:0] trim_term;
		logic [tpsc_pkg::SYNTH_WORD_W-1:0] base_term;
		spacing = scale(slot_spacing_mant_in, {2'b00, slot_spacing_exp_in});
		slot_term = tpsc_pkg::SYNTH_WORD_W'({24'h000000, rf_slot_index} *
			{8'h00, spacing});
		trim_term = tpsc_pkg::SYNTH_WORD_W'({{19{carrier_trim[7]}},
			carrier_trim} << tpsc_pkg::TRIM_SHIFT);
		base_term = tpsc_pkg::SYNTH_WORD_W'({3'b000, base_carrier_word}
			<< tpsc_pkg::CARRIER_SHIFT);
		// wraps modulo the word width if the trim drives it negative
		next_synth_word = base_term + slot_term + trim_term;
	end

	// rate word, divide by 2^28 left to the modem
	assign next_rate_word = scale(symbol_rate_mant, symbol_rate_exp);

	// derived words registered to break the multiplier path
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			synth_word_out <= '0;
			symbol_rate_word_out <= '0;
		end else begin
			synth_word_out <= next_synth_word;
			symbol_rate_word_out <= next_rate_word;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// payload size selection by policy
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			payload_size_out <= 8'h00;
			payload_size_valid_out <= 1'b0;
			unbounded_packet_out <= 1'b0;
		end else begin
			unique case (tpsc_pkg::tpsc_size_e'(size_policy))
				tpsc_pkg::TPSC_SIZE_FIXED: begin
					payload_size_out <= fixed_payload_size;
					payload_size_valid_out <= 1'b1;
					unbounded_packet_out <= 1'b0;
				end
				tpsc_pkg::TPSC_SIZE_FIRST_BYTE: begin
					if (fifo_first_byte_valid_in) begin
						payload_size_out <= fifo_first_byte_in;
					end
					payload_size_valid_out <= fifo_first_byte_valid_in;
					unbounded_packet_out <= 1'b0;
				end
				tpsc_pkg::TPSC_SIZE_UNBOUNDED: begin
					payload_size_out <= 8'h00;
					payload_size_valid_out <= 1'b0;
					unbounded_packet_out <= 1'b1;
				end
				tpsc_pkg::TPSC_SIZE_RESERVED: begin
					// reserved code: treated as no packet size
					payload_size_out <= 8'h00;
					payload_size_valid_out <= 1'b0;
					unbounded_packet_out <= 1'b0;
				end
			endcase
		end
	end

	// registered copies of the packet configuration
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			sync_pattern_out <= {tpsc_pkg::RST_SYNC_HIGH,
				tpsc_pkg::RST_SYNC_LOW};
			check_append_out <= tpsc_pkg::RST_CHECK_EN;
			data_source_format_out <= tpsc_pkg::RST_SOURCE_FMT;
		end else begin
			sync_pattern_out <= {sync_pattern_high, sync_pattern_low};
			check_append_out <= check_enable;
			data_source_format_out <= data_source_format;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// transmit bit source
	tpsc_source u_source (
		.ref_clk_in(ref_clk_in),
		.rst_in(rst_in),
		.data_source_format_in(data_source_format),
		.bit_adv_in(bit_adv_in),
		.fifo_bit_in(fifo_bit_in),
		.gp_pin_zero_in(gp_pin_zero_in),
		.tx_bit_out(tx_bit_out),
		.packet_handling_out(packet_handling_out)
	);

endmodule

// [core/tpsc_source.sv]
// transmit bit source: fifo, pin zero, or nine stage prbs
module tpsc_source (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_in,
	// configuration
	input wire logic [1:0] data_source_format_in,
	// bit timing
	input wire logic bit_adv_in,
	// candidate bits
	input wire logic fifo_bit_in,
	input wire logic gp_pin_zero_in,
	// result
	output logic tx_bit_out,
	output logic packet_handling_out
);

	// nine stage shift register, x^9 + x^5 + 1
	logic [8:0] nine_stage_prbs;
	logic next_tx_bit;

	////////////////////////////////////////////////////////////////////////
	// prbs steps once per bit, only while selected
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			nine_stage_prbs <= tpsc_pkg::RST_PRBS_SEED;
		end else if (bit_adv_in &&
			data_source_format_in == tpsc_pkg::TPSC_SRC_PRBS) begin
			nine_stage_prbs <= {nine_stage_prbs[7:0],
				nine_stage_prbs[8] ^ nine_stage_prbs[4]};
		end
	end

	// pick the source for the current mode
	always_comb begin
		unique case (tpsc_pkg::tpsc_source_e'(data_source_format_in))
			tpsc_pkg::TPSC_SRC_FIFO: next_tx_bit = fifo_bit_in;
			tpsc_pkg::TPSC_SRC_SYNC_SER: next_tx_bit = gp_pin_zero_in;
			tpsc_pkg::TPSC_SRC_PRBS: next_tx_bit = nine_stage_prbs[8];
			tpsc_pkg::TPSC_SRC_ASYNC_SER: next_tx_bit = gp_pin_zero_in;
		endcase
	end

	// output bit registered; updated on each bit strobe
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			tx_bit_out <= 1'b0;
		end else if (bit_adv_in) begin
			tx_bit_out <= next_tx_bit;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			packet_handling_out <= 1'b1;
		end else begin
			packet_handling_out <= data_source_format_in !=
				tpsc_pkg::TPSC_SRC_ASYNC_SER;
		end
	end

endmodule

// [shared/tpsc_pkg.sv]
package tpsc_pkg;

	////////////////////////////////////////////////////////////////////////
	// register offsets on the configuration port
	localparam logic [5:0] ADDR_SYNC_HIGH = 6'h04;
	localparam logic [5:0] ADDR_SYNC_LOW = 6'h05;
	localparam logic [5:0] ADDR_PAYLOAD_SIZE = 6'h06;
	localparam logic [5:0] ADDR_PKT_CTRL = 6'h08;
	localparam logic [5:0] ADDR_SLOT_INDEX = 6'h0a;
	localparam logic [5:0] ADDR_OFFSET_TRIM = 6'h0c;
	localparam logic [5:0] ADDR_CARRIER_HIGH = 6'h0d;
	localparam logic [5:0] ADDR_CARRIER_MID = 6'h0e;
	localparam logic [5:0] ADDR_CARRIER_LOW = 6'h0f;
	localparam logic [5:0] ADDR_RATE_EXP = 6'h10;
	localparam logic [5:0] ADDR_RATE_MANT = 6'h11;

	////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [7:0] RST_SYNC_HIGH = 8'hd3;
	localparam logic [7:0] RST_SYNC_LOW = 8'h91;
	localparam logic [7:0] RST_PAYLOAD_SIZE = 8'hff;
	localparam logic [7:0] RST_SLOT_INDEX = 8'h00;
	localparam logic [7:0] RST_OFFSET_TRIM = 8'h00;
	localparam logic [5:0] RST_CARRIER_HIGH = 6'h1e;
	localparam logic [7:0] RST_CARRIER_MID = 8'hc4;
	localparam logic [7:0] RST_CARRIER_LOW = 8'hec;
	localparam logic [3:0] RST_RATE_UPPER = 4'h8;
	localparam logic [3:0] RST_RATE_EXP = 4'hc;
	localparam logic [7:0] RST_RATE_MANT = 8'h22;
	localparam logic RST_PKT_TUNE = 1'b1;
	localparam logic [1:0] RST_SOURCE_FMT = 2'h0;
	localparam logic RST_CHECK_EN = 1'b1;
	localparam logic [1:0] RST_SIZE_POLICY = 2'h1;
	localparam logic [8:0] RST_PRBS_SEED = 9'h1ff;

	////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int PKT_TUNE_BIT = 6;
	localparam int SOURCE_FMT_LSB = 4;
	localparam int CHECK_EN_BIT = 2;
	localparam int SIZE_POLICY_LSB = 0;
	localparam int HDR_READ_BIT = 7;
	localparam int HDR_BURST_BIT = 6;

	////////////////////////////////////////////////////////////////////////
	// scaling: every frequency term is brought to f_xtal / 2^18 units
	localparam int CARRIER_SHIFT = 2;
	localparam int TRIM_SHIFT = 4;
	localparam logic [8:0] HIDDEN_ONE = 9'h100;
	localparam int SYNTH_WORD_W = 27;
	localparam int RATE_WORD_W = 24;

	////////////////////////////////////////////////////////////////////////
	// modes
	typedef enum logic [1:0] {
		TPSC_SRC_FIFO = 2'b00,
		TPSC_SRC_SYNC_SER = 2'b01,
		TPSC_SRC_PRBS = 2'b10,
		TPSC_SRC_ASYNC_SER = 2'b11
	} tpsc_source_e;

	typedef enum logic [1:0] {
		TPSC_SIZE_FIXED = 2'b00,
		TPSC_SIZE_FIRST_BYTE = 2'b01,
		TPSC_SIZE_UNBOUNDED = 2'b10,
		TPSC_SIZE_RESERVED = 2'b11
	} tpsc_size_e;

endpackage

// [test/tpsc_host_model.sv]
// host side of the configuration port, bit-banged on the falling edge
module tpsc_host_model (
	// clock
	input wire logic ref_clk_in,
	// serial port
	input wire logic miso_in,
	output logic sclk_out,
	output logic cs_n_out,
	output logic mosi_out
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle: clock parked low, frame deselected
	initial begin
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		mosi_out = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// one frame: header then nb data bytes, msb first
	// each sclk phase spans two ref clocks; the port needs only one to see it
	task automatic frame(input logic [7:0] hdr, input logic [15:0] wd,
		input int nb, output logic [15:0] rd);
		logic [23:0] sh;
		sh = {hdr, wd};
		rd = 16'h0000;
		@(negedge ref_clk_in);
		cs_n_out = 1'b0;
		for (int i = 0; i < 8 + 8 * nb; i++) begin
			mosi_out = sh[23 - i];
			repeat (2) @(negedge ref_clk_in);
			// read bit taken just before the rise, as a mode 0 master does
			if (i >= 8) begin
				rd = {rd[14:0], miso_in};
			end
			sclk_out = 1'b1;
			repeat (2) @(negedge ref_clk_in);
			sclk_out = 1'b0;
		end
		repeat (2) @(negedge ref_clk_in);
		cs_n_out = 1'b1;
		// released line shows no stale value
		mosi_out = ~mosi_out;
		repeat (2) @(negedge ref_clk_in);
	endtask
endmodule

// [test/tpsc_regs_monitor.sv]
// watches the register bank's ports
module tpsc_regs_monitor (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_in,
	// bit source
	input wire logic bit_adv_in,
	input wire logic gp_pin_zero_in,
	// configuration outputs
	input wire logic [15:0] sync_pattern_out,
	input wire logic payload_size_valid_out,
	input wire logic unbounded_packet_out,
	input wire logic check_append_out,
	input wire logic [1:0] data_source_format_out,
	input wire logic tx_bit_out,
	input wire logic packet_handling_out,
	input wire logic [tpsc_pkg::SYNTH_WORD_W-1:0] synth_word_out,
	input wire logic [tpsc_pkg::RATE_WORD_W-1:0] symbol_rate_word_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking mon_cb @(posedge ref_clk_in);
	endclocking
	default disable iff (rst_in);

	sync_reset_a: assert property (
		$fell(rst_in) |-> sync_pattern_out == 16'hd391)
		else $error("sync pattern not at reset value");
	size_reset_a: assert property (
		$fell(rst_in) |-> !payload_size_valid_out && !unbounded_packet_out)
		else $error("size outputs set out of reset");
	check_reset_a: assert property (
		$fell(rst_in) |-> check_append_out)
		else $error("check append off out of reset");
	async_nopkt_a: assert property (
		(data_source_format_out == 2'b11) [*2] |-> !packet_handling_out)
		else $error("packet handling on in async mode");
	pkt_handling_a: assert property (
		(data_source_format_out != 2'b11) [*2] |-> packet_handling_out)
		else $error("packet handling off outside async mode");
	bit_hold_a: assert property (
		$changed(tx_bit_out) |-> $past(bit_adv_in))
		else $error("transmit bit moved without advance");
	pin_follow_a: assert property (
		bit_adv_in && data_source_format_out[0] |=>
		tx_bit_out == $past(gp_pin_zero_in))
		else $error("transmit bit not taken from pin");
	rate_reset_a: assert property (
		$fell(rst_in) |=> symbol_rate_word_out == 24'h122000)
		else $error("rate word wrong after reset");
	synth_reset_a: assert property (
		$fell(rst_in) |=> synth_word_out == 27'h07b13b0)
		else $error("synth word wrong after reset");
endmodule

bind tpsc_regs tpsc_regs_monitor mon_u (
	.ref_clk_in(ref_clk_in),
	.rst_in(rst_in),
	.bit_adv_in(bit_adv_in),
	.gp_pin_zero_in(gp_pin_zero_in),
	.sync_pattern_out(sync_pattern_out),
	.payload_size_valid_out(payload_size_valid_out),
	.unbounded_packet_out(unbounded_packet_out),
	.check_append_out(check_append_out),
	.data_source_format_out(data_source_format_out),
	.tx_bit_out(tx_bit_out),
	.packet_handling_out(packet_handling_out),
	.synth_word_out(synth_word_out),
	.symbol_rate_word_out(symbol_rate_word_out)
);

// [test/tx_packet_synth_config_regs_tb.sv]
module tx_packet_synth_config_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic sclk, cs_n, mosi, miso;
	logic [7:0] spc_m = 8'hf8;
	logic [1:0] spc_e = 2'h2;
	logic ffv = 1'b0, fbit = 1'b0, pin = 1'b0, adv = 1'b0;
	logic [7:0] ffb = 8'h00;
	logic [15:0] sync;
	logic [7:0] psize;
	logic pvalid, unb, chk_on, txb, handling;
	logic [1:0] fmt;
	logic [26:0] synth;
	logic [23:0] rate;
	int fail_count = 0;
	int comparisons = 0;
	// reset image, unmapped address last
	logic [5:0] ra [12] = '{6'h04, 6'h05, 6'h06, 6'h08, 6'h0a, 6'h0c,
		6'h0d, 6'h0e, 6'h0f, 6'h10, 6'h11, 6'h07};
	logic [7:0] rv [12] = '{8'hd3, 8'h91, 8'hff, 8'h45, 8'h00, 8'h00,
		8'h1e, 8'hc4, 8'hec, 8'h8c, 8'h22, 8'h00};

	always #4 clk = ~clk;

	////////////////////////////////////////////////////////////////////////
	tpsc_host_model host_u (.ref_clk_in(clk), .miso_in(miso),
		.sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi));
	tpsc_regs dut_u (.ref_clk_in(clk), .rst_in(rst), .spi_sclk_in(sclk),
		.spi_cs_n_in(cs_n), .spi_mosi_in(mosi), .spi_miso_out(miso),
		.slot_spacing_mant_in(spc_m), .slot_spacing_exp_in(spc_e),
		.fifo_first_byte_valid_in(ffv), .fifo_first_byte_in(ffb),
		.fifo_bit_in(fbit), .gp_pin_zero_in(pin), .bit_adv_in(adv),
		.sync_pattern_out(sync), .payload_size_out(psize),
		.payload_size_valid_out(pvalid), .unbounded_packet_out(unb),
		.check_append_out(chk_on), .data_source_format_out(fmt),
		.tx_bit_out(txb), .packet_handling_out(handling),
		.synth_word_out(synth), .symbol_rate_word_out(rate));

	////////////////////////////////////////////////////////////////////////
	// comparisons, four-state exact
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] e);
		comparisons++;
		if (got !== e) begin
			fail_count++;
			$display("ERROR %0t read %h expected %h", $time, got, e);
		end
	endtask
	task automatic chk_wide(input logic [26:0] got, input logic [26:0] e);
		comparisons++;
		if (got !== e) begin
			fail_count++;
			$display("ERROR %0t value %h expected %h", $time, got, e);
		end
	endtask
	task automatic print_verdict();
		if (fail_count == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// single byte write, then room for derived outputs to settle
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		logic [15:0] r;
		host_u.frame({2'b00, a}, {d, 8'h00}, 1, r);
		repeat (3) @(negedge clk);
	endtask
	task automatic rchk(input logic [5:0] a, input logic [7:0] e);
		logic [15:0] r;
		host_u.frame({2'b10, a}, 16'h0000, 1, r);
		chk_byte(r[7:0], e);
	endtask
	// one-cycle bit advance, sampled a cycle later
	task automatic pulse();
		adv = 1'b1;
		@(negedge clk);
		adv = 1'b0;
		@(negedge clk);
	endtask

	////////////////////////////////////////////////////////////////////////
	// watchdog, far beyond the few thousand cycles the tests need
	initial begin
		repeat (40000) @(posedge clk);
		fail_count++;
		print_verdict();
	end

	initial begin
		int ones;
		int exp_w;
		logic [15:0] r16;
		repeat (16) @(negedge clk);
		rst = 1'b0;
		repeat (2) @(negedge clk);
		chk_wide(synth, 27'h07b13b0);
		chk_wide(27'(rate), 27'h0122000);
		chk_wide(27'({pvalid, unb, chk_on, fmt, handling}), 27'h9);
		for (int i = 0; i < 12; i++) rchk(ra[i], rv[i]);
		wr(6'h0d, 8'hff);
		rchk(6'h0d, 8'h3f);
		wr(6'h08, 8'hff);
		rchk(6'h08, 8'h77);
		wr(6'h07, 8'ha5);
		rchk(6'h07, 8'h00);
		// burst write then burst read across both sync bytes
		host_u.frame(8'h44, 16'hbeef, 2, r16);
		repeat (3) @(negedge clk);
		chk_wide(27'(sync), 27'hbeef);
		host_u.frame(8'hc4, 16'h0000, 2, r16);
		chk_wide(27'(r16), 27'hbeef);
		wr(6'h06, 8'h2a);
		wr(6'h08, 8'h44);
		chk_wide(27'({pvalid, unb, psize}), 27'h22a);
		ffb = 8'h13;
		ffv = 1'b1;
		wr(6'h08, 8'h45);
		chk_wide(27'({pvalid, unb, psize}), 27'h213);
		wr(6'h08, 8'h46);
		chk_wide(27'({pvalid, unb}), 27'h1);
		wr(6'h08, 8'h47);
		chk_wide(27'({pvalid, unb}), 27'h0);
		wr(6'h08, 8'h40);
		chk_wide(27'(chk_on), 27'h0);
		// every source format, fifo and pin driven opposite
		for (int f = 0; f < 4; f++) begin
			wr(6'h08, {2'b01, 2'(f), 4'h5});
			chk_wide(27'({fmt, handling}), 27'({2'(f), f != 3}));
			for (int v = 0; v < 2; v++) begin
				fbit = v[0];
				pin = ~v[0];
				pulse();
				if (f != 2) chk_wide(27'(txb), 27'(f == 0 ? v[0] : !v[0]));
			end
		end
		// a full prbs period holds 256 ones whatever the phase
		wr(6'h08, 8'h65);
		ones = 0;
		repeat (511) begin
			pulse();
			ones += int'(txb);
		end
		chk_wide(27'(ones), 27'h100);
		wr(6'h0d, 8'h10);
		wr(6'h0e, 8'h00);
		wr(6'h0f, 8'h01);
		wr(6'h0a, 8'h03);
		wr(6'h0c, 8'hfe);
		exp_w = 4 * 32'h100001 + 3 * ((256 + 248) << 2) - 32;
		chk_wide(synth, 27'(exp_w));
		spc_m = 8'h00;
		spc_e = 2'h0;
		repeat (3) @(negedge clk);
		chk_wide(synth, 27'(4 * 32'h100001 + 3 * 256 - 32));
		wr(6'h10, 8'h8f);
		wr(6'h11, 8'hff);
		chk_wide(27'(rate), 27'(511 << 15));
		print_verdict();
	end
endmodule
